// ---- hdl/pbseq_pkg.sv ----
// Constants and types shared by the push-button power sequencer.
// Assumes a single 100 MHz clock; all durations derive from it.
package pbseq_pkg;
  // ****************************************
  // Clock and time base
  // ****************************************
  localparam int CLK_HZ = 100_000_000;
  localparam int MS_PER_S = 1000;
  localparam int US_PER_S = 1_000_000;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int TICK_W = 17;
  localparam int TMR_W = 11;
  localparam int EXT_W = 10;
  localparam int FILT_W = 12;

  // ****************************************
  // Durations, in their own units
  // ****************************************
  localparam int KILL_FILT_US = 30;
  localparam int KILL_FILT_CYC = (CLK_HZ / US_PER_S) * KILL_FILT_US;
  localparam logic [FILT_W-1:0] KILL_FILT_MAX = FILT_W'(KILL_FILT_CYC - 1);
  localparam logic [TMR_W-1:0] DB_BASE_MS = 11'h020;
  localparam logic [TMR_W-1:0] DB_OFFSET_MS = 11'h001;
  localparam logic [TMR_W-1:0] RELEASE_DB_MS = 11'h020;
  localparam logic [TMR_W-1:0] BLANK_MS = 11'h200;
  localparam logic [TMR_W-1:0] OFF_DELAY_MS = 11'h400;
  localparam logic [TMR_W-1:0] LOCKOUT_MS = 11'h100;
  localparam logic [TMR_W-1:0] TMR_MAX = 11'h7ff;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    ST_OFF_REL = 3'b000,
    ST_OFF_IDLE = 3'b001,
    ST_ON_BLANK = 3'b010,
    ST_ON_REL = 3'b011,
    ST_ON_RUN = 3'b100,
    ST_OFF_PEND = 3'b101,
    ST_LOCKOUT = 3'b110
  } pbseq_state_t;

  // Press debounce length in ms; zero extension means the bare base time
  function automatic logic [TMR_W-1:0] dbTarget(input logic [EXT_W-1:0] ext);
    dbTarget = (ext == '0) ? DB_BASE_MS : DB_BASE_MS + DB_OFFSET_MS + {1'b0, ext};
  endfunction : dbTarget
endpackage : pbseq_pkg

// ---- hdl/pbseq_kill_if.sv ----
// Carries the filtered shutdown-request level to the sequencer.
// Assumes both ends run on the sequencer clock.
`timescale 1ns/100ps
`default_nettype none
interface pbseq_kill_if;
  logic killLow;
  logic lowSeen;
  modport src (output killLow, output lowSeen);
  modport snk (input killLow);
endinterface : pbseq_kill_if
`default_nettype wire

// ---- hdl/pbseq_kill_filter.sv ----
// Synchroniser and low-pulse filter for the shutdown request pin.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module pbseq_kill_filter
  import pbseq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pin
  input wire logic killInput,
  // Filtered level
  pbseq_kill_if.src kill
);
  logic meta_r;
  logic sync_r;
  logic [FILT_W-1:0] cnt_r;
  logic [FILT_W-1:0] cnt_nxt;
  logic low_r;
  logic low_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    low_nxt = low_r;
    if (sync_r) begin
      // Any high sample restarts the qualification
      cnt_nxt = '0; // R8
      low_nxt = 1'b0;
    end else if (cnt_r == KILL_FILT_MAX) begin
      low_nxt = 1'b1; // R8 R9
    end else begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      cnt_r <= '0;
      low_r <= 1'b0;
    end else begin
      meta_r <= killInput;
      sync_r <= meta_r;
      cnt_r <= cnt_nxt;
      low_r <= low_nxt;
    end
  end

  assign kill.killLow = low_r;
  assign kill.lowSeen = !sync_r;

  // A fresh low never reaches the sequencer within 8 cycles of the fall
  filter_holds_a: assert property (@(posedge clk) disable iff (rst) // R8
    $rose(!sync_r) |=> !low_r [*8]) else $error("kill filter passed a short low");
endmodule : pbseq_kill_filter
`default_nettype wire

// ---- hdl/pbseq_sequencer.sv ----
// Push-button power on/off sequencer with host shutdown handshake.
// Assumes button and shutdown pins are asynchronous; extensions are static straps.
// Contract
// R1: Two variants differ only in enable output polarity.
// R2: On and off debounce each take an independent extension setting.
// R3: Without extension the button must stay low 32 ms.
// R4: After turn-off press, enable releases within 1024 ms regardless of host.
// R5: Host should pull shutdown request low before the 1024 ms expires.
// R6: Debounce equals 32 ms plus 1 ms plus linear extension.
// R7: Shutdown request low in normal running releases enable at once.
// R8: Shutdown request lows shorter than 30 us are ignored.
// R9: Enable goes open 30 us after shutdown request falls; the high-true variant pulls it low instead.
// R10: Valid presses alternately turn enable on and off.
// R11: Blank inputs 512 ms after turn-on; then release unless request high.
// R12: Completed turn-off debounce pulls interrupt low and starts 1024 ms timer.
// R13: Button returning high restarts the debounce timer.
// R14: After enable release, ignore button for 256 ms.
// R15: Reset leaves enable off, interrupt released, waiting for a press.
// R16: Timers count a single 1 ms time base, wide enough for all durations.
`timescale 1ns/100ps
`default_nettype none
module pbseq_sequencer
  import pbseq_pkg::*;
#(
  parameter int TICK_CYCLES = MS_CYCLES,
  parameter bit ACTIVE_LOW = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Push button and host pins
  input wire logic buttonInputN,
  input wire logic killInput,
  // Debounce extensions in ms
  input wire logic [EXT_W-1:0] turnOnExtension,
  input wire logic [EXT_W-1:0] turnOffExtension,
  // Open-drain enable
  output logic enableOut,
  output logic enableOe,
  // Open-drain power-down interrupt, low active
  output logic intOut,
  output logic intOe
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  logic btnMeta_r;
  logic btnSync_r;
  pbseq_kill_if killBus ();

  pbseq_kill_filter u_kill (
    .clk(clk),
    .rst(rst),
    .killInput(killInput),
    .kill(killBus.src)
  );

  // ****************************************
  // Time base and sequence timer
  // ****************************************
  logic [TICK_W-1:0] tick_r;
  logic [TICK_W-1:0] tick_nxt;
  logic [TMR_W-1:0] tmr_r;
  logic [TMR_W-1:0] tmr_nxt;
  logic [TMR_W-1:0] target;
  logic msTick;
  logic clearTmr;
  logic restart;
  logic done;
  logic killLow;

  assign killLow = killBus.killLow;
  assign msTick = (tick_r == TICK_W'(TICK_CYCLES - 1)); // R16
  assign done = (tmr_r >= target);

  always_comb begin
    clearTmr = restart;
    tick_nxt = msTick ? '0 : tick_r + 1'b1;
    tmr_nxt = (msTick && tmr_r != TMR_MAX) ? tmr_r + 1'b1 : tmr_r; // R16
    // Phase restart keeps each duration exact to the cycle
    if (clearTmr) begin
      tick_nxt = '0;
      tmr_nxt = '0;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  pbseq_state_t state_r;
  pbseq_state_t state_nxt;
  logic enOn;
  logic enableOe_nxt;
  logic intOe_nxt;

  always_comb begin
    state_nxt = state_r;
    restart = 1'b0;
    target = RELEASE_DB_MS;
    unique case (state_r)
      ST_OFF_REL: begin
        // Button must be seen released before a new press counts
        if (!btnSync_r) begin
          restart = 1'b1;
        end else if (done) begin
          state_nxt = ST_OFF_IDLE; // R15
        end
      end
      ST_OFF_IDLE: begin
        target = dbTarget(turnOnExtension); // R2 R3 R6
        if (btnSync_r) begin
          restart = 1'b1; // R13
        end else if (done) begin
          state_nxt = ST_ON_BLANK; // R10
        end
      end
      ST_ON_BLANK: begin
        target = BLANK_MS;
        if (done) begin
          state_nxt = killLow ? ST_LOCKOUT : ST_ON_REL; // R11
        end
      end
      ST_ON_REL: begin
        if (killLow) begin
          state_nxt = ST_LOCKOUT; // R7
        end else if (!btnSync_r) begin
          restart = 1'b1;
        end else if (done) begin
          state_nxt = ST_ON_RUN;
        end
      end
      ST_ON_RUN: begin
        target = dbTarget(turnOffExtension); // R2 R6
        if (killLow) begin
          state_nxt = ST_LOCKOUT; // R7
        end else if (btnSync_r) begin
          restart = 1'b1; // R13
        end else if (done) begin
          state_nxt = ST_OFF_PEND; // R10 R12
        end
      end
      ST_OFF_PEND: begin
        target = OFF_DELAY_MS;
        // Host releases early; the timer forces it otherwise
        if (killLow || done) begin
          state_nxt = ST_LOCKOUT; // R4 R5
        end
      end
      ST_LOCKOUT: begin
        target = LOCKOUT_MS;
        if (done) begin
          state_nxt = ST_OFF_REL; // R14
        end
      end
      default: begin
        state_nxt = ST_OFF_REL;
      end
    endcase
    if (state_nxt != state_r) begin
      restart = 1'b1;
    end
  end

  always_comb begin
    enOn = (state_nxt == ST_ON_BLANK) || (state_nxt == ST_ON_REL) ||
      (state_nxt == ST_ON_RUN) || (state_nxt == ST_OFF_PEND);
    // High-true variant asserts by letting go; low-true by pulling down
    enableOe_nxt = ~(enOn ^ ACTIVE_LOW); // R1
    intOe_nxt = (state_nxt == ST_OFF_PEND); // R12
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      btnMeta_r <= 1'b1;
      btnSync_r <= 1'b1;
      tick_r <= '0;
      tmr_r <= '0;
      state_r <= ST_OFF_REL; // R15
      enableOe <= ~ACTIVE_LOW;
      enableOut <= 1'b0;
      intOe <= 1'b0;
      intOut <= 1'b0;
    end else begin
      btnMeta_r <= buttonInputN;
      btnSync_r <= btnMeta_r;
      tick_r <= tick_nxt;
      tmr_r <= tmr_nxt;
      state_r <= state_nxt;
      enableOe <= enableOe_nxt;
      enableOut <= 1'b0;
      intOe <= intOe_nxt;
      intOut <= 1'b0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic onNow;
  assign onNow = (enableOe == ACTIVE_LOW);

  kill_release_a: assert property (@(posedge clk) disable iff (rst) // R7
    state_r == ST_ON_RUN && killLow |=> state_r == ST_LOCKOUT ##1 !onNow)
    else $error("kill did not release enable");
  blank_ignore_a: assert property (@(posedge clk) disable iff (rst) // R11
    state_r == ST_ON_BLANK && !done |=> state_r == ST_ON_BLANK && onNow)
    else $error("blanking left early");
  int_pend_a: assert property (@(posedge clk) disable iff (rst) // R12
    intOe == (state_r == ST_OFF_PEND)) else $error("interrupt out of step");
  forced_off_a: assert property (@(posedge clk) disable iff (rst) // R4
    state_r == ST_OFF_PEND && tmr_r == OFF_DELAY_MS |=> !onNow && state_r == ST_LOCKOUT)
    else $error("forced turn-off missed");
  db_restart_a: assert property (@(posedge clk) disable iff (rst) // R13
    (state_r == ST_OFF_IDLE || state_r == ST_ON_RUN) && btnSync_r |=> tmr_r == '0 && tick_r == '0)
    else $error("debounce not restarted");
  lockout_hold_a: assert property (@(posedge clk) disable iff (rst) // R14
    state_r == ST_LOCKOUT |=> (state_r == ST_LOCKOUT || state_r == ST_OFF_REL) && !onNow)
    else $error("button accepted in lockout");
  press_on_a: assert property (@(posedge clk) disable iff (rst) // R10
    state_r == ST_OFF_IDLE && !btnSync_r && done |=> state_r == ST_ON_BLANK && onNow)
    else $error("press did not turn on");
  db_length_a: assert property (@(posedge clk) disable iff (rst) // R3
    state_r == ST_OFF_IDLE && turnOnExtension == '0 |-> target == DB_BASE_MS)
    else $error("base debounce wrong");
  tick_step_a: assert property (@(posedge clk) disable iff (rst) // R16
    !restart && !msTick |=> $stable(tmr_r)) else $error("timer moved off tick");

  powered_on_c: cover property (@(posedge clk) disable iff (rst) state_r == ST_ON_RUN);
  forced_off_c: cover property (@(posedge clk) disable iff (rst) state_r == ST_OFF_PEND && done);
  aborted_on_c: cover property (@(posedge clk) disable iff (rst)
    state_r == ST_ON_BLANK && done && killLow);
  host_off_c: cover property (@(posedge clk) disable iff (rst) state_r == ST_OFF_PEND && killLow);
  // Host line dipped while running but not yet qualified
  glitch_seen_c: cover property (@(posedge clk) disable iff (rst)
    state_r == ST_ON_RUN && killBus.lowSeen && !killLow);
endmodule : pbseq_sequencer
`default_nettype wire

// ---- sim/pbseq_partner.sv ----
// Push button and host model for the sequencer pins.
// Assumes the bench calls its tasks; the button line idles high on its pull-up, the host line starts low.
`timescale 1ns/100ps
`default_nettype none
module pbseq_partner (
  // Clock
  input wire logic clk,
  // Pins
  output var logic buttonInputN,
  output var logic killInput
);
  // Host unpowered at start, so its line sits low
  initial begin
    buttonInputN = 1'b1;
    killInput = 1'b0;
  end
  // Button switch to ground, pull-up when open
  task automatic button(input logic down);
    @(negedge clk);
    buttonInputN = ~down;
  endtask : button
  // Host drives high after boot, low when done
  task automatic host(input logic pullLow);
    @(negedge clk);
    killInput = ~pullLow;
  endtask : host
endmodule : pbseq_partner
`default_nettype wire

// ---- sim/test_push_button_power_sequencer.sv ----
// Self-checking bench for the push-button power sequencer.
// Assumes a 10-cycle time base, so one ms of the rules is 10 clocks.
`timescale 1ns/100ps
`default_nettype none
module test_push_button_power_sequencer;
  import pbseq_pkg::*;
  localparam int TICK = 10;
  logic clk;
  logic rst;
  logic buttonInputN;
  logic killInput;
  logic [EXT_W-1:0] onExt;
  logic [EXT_W-1:0] offExt;
  logic enOe;
  logic enOeN;
  logic intOe;
  logic intOeN;
  logic [3:0] odData;
  logic [EXT_W-1:0] rnd;
  int err_count = 0;
  int cmp_count = 0;
  int n;
  int e;

  pbseq_partner i_pbseq_partner (.clk(clk), .buttonInputN(buttonInputN), .killInput(killInput));
  pbseq_sequencer #(.TICK_CYCLES(TICK), .ACTIVE_LOW(1'b0)) i_pbseq_sequencer (
    .clk(clk), .rst(rst), .buttonInputN(buttonInputN), .killInput(killInput),
    .turnOnExtension(onExt), .turnOffExtension(offExt),
    .enableOut(odData[0]), .enableOe(enOe), .intOut(odData[1]), .intOe(intOe));
  // Low-true variant on the same pins
  pbseq_sequencer #(.TICK_CYCLES(TICK), .ACTIVE_LOW(1'b1)) i_pbseq_sequencer_low (
    .clk(clk), .rst(rst), .buttonInputN(buttonInputN), .killInput(killInput),
    .turnOnExtension(onExt), .turnOffExtension(offExt),
    .enableOut(odData[2]), .enableOe(enOeN), .intOut(odData[3]), .intOe(intOeN));

  // ****************************************
  // Checks and waits
  // ****************************************
  task automatic print_verdict();
    $display("Compares %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  // Both variants at once: pin pulled low means off for one, on for the other
  // Open-drain data lines must never leave low
  task automatic chkLvl(input logic on, input logic irq);
    cmp_count++;
    if ({enOe, enOeN, intOe, intOeN, odData} !== {~on, on, irq, irq, 4'h0}) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time,
        {enOe, enOeN, intOe, intOeN, odData}, {~on, on, irq, irq, 4'h0});
    end
  endtask : chkLvl

  // Slack covers sampling phase only; a 1 ms slip is 10 clocks
  task automatic chkTime(input int got, input int exp);
    cmp_count++;
    if (got > exp + 3 || got + 3 < exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkTime

  task automatic waitFor(input bit isInt, input logic lvl, input int limit, output int cnt);
    cnt = 0;
    while (((isInt ? intOe : enOe) !== lvl) && cnt < limit) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    if (cnt >= limit) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, isInt ? intOe : enOe, lvl);
      print_verdict();
    end
  endtask : waitFor

  task automatic idle(input int ms);
    repeat (ms * TICK) @(negedge clk);
  endtask : idle

  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    onExt = '0;
    offExt = '0;
    e = $urandom(86);
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chkLvl(1'b0, 1'b0);
    idle(40);
    // Press too short, then a full press timed from its own start
    i_pbseq_partner.button(1'b1);
    idle(20);
    i_pbseq_partner.button(1'b0);
    idle(5);
    chkLvl(1'b0, 1'b0);
    i_pbseq_partner.button(1'b1);
    waitFor(1'b0, 1'b0, 400, n);
    chkTime(n, 2 + 32 * TICK + 1);
    chkLvl(1'b1, 1'b0);
    $display("Test plain_on done");
    // Host stays low through blanking: power-on aborts
    waitFor(1'b0, 1'b1, 5300, n);
    chkTime(n, 512 * TICK);
    i_pbseq_partner.button(1'b0);
    idle(100);
    i_pbseq_partner.button(1'b1);
    idle(100);
    i_pbseq_partner.button(1'b0);
    chkLvl(1'b0, 1'b0);
    idle(200);
    $display("Test abort_lockout done");
    // Random on extension, host boots in time
    rnd = EXT_W'($urandom_range(1, 1022));
    onExt = rnd;
    e = onExt;
    i_pbseq_partner.button(1'b1);
    waitFor(1'b0, 1'b0, 10700, n);
    chkTime(n, 2 + (33 + e) * TICK + 1);
    i_pbseq_partner.host(1'b0);
    idle(20);
    i_pbseq_partner.button(1'b0);
    idle(600);
    chkLvl(1'b1, 1'b0);
    // Host glitch shorter than the filter
    i_pbseq_partner.host(1'b1);
    repeat (2500) @(negedge clk);
    i_pbseq_partner.host(1'b0);
    idle(5);
    chkLvl(1'b1, 1'b0);
    $display("Test boot_glitch done");
    // Off press, host never answers
    // Complement makes every strap bit toggle over the run
    offExt = ~rnd;
    e = offExt;
    i_pbseq_partner.button(1'b1);
    waitFor(1'b1, 1'b1, 10700, n);
    chkTime(n, 2 + (33 + e) * TICK + 1);
    chkLvl(1'b1, 1'b1);
    i_pbseq_partner.button(1'b0);
    waitFor(1'b0, 1'b1, 10400, n);
    chkTime(n, 1024 * TICK);
    chkLvl(1'b0, 1'b0);
    $display("Test forced_off done");
    // Back on, then host pulls its line low while running
    idle(300);
    onExt = ~rnd;
    offExt = rnd;
    e = onExt;
    i_pbseq_partner.button(1'b1);
    waitFor(1'b0, 1'b0, 10700, n);
    chkTime(n, 2 + (33 + e) * TICK + 1);
    idle(20);
    i_pbseq_partner.button(1'b0);
    idle(600);
    i_pbseq_partner.host(1'b1);
    waitFor(1'b0, 1'b1, 3200, n);
    chkTime(n, KILL_FILT_CYC + 3);
    chkLvl(1'b0, 1'b0);
    $display("Test host_off done");
    // Off press answered by the host before the forced delay
    idle(300);
    onExt = '0;
    e = offExt;
    i_pbseq_partner.host(1'b0);
    i_pbseq_partner.button(1'b1);
    waitFor(1'b0, 1'b0, 400, n);
    chkTime(n, 2 + 32 * TICK + 1);
    idle(20);
    i_pbseq_partner.button(1'b0);
    idle(540);
    i_pbseq_partner.button(1'b1);
    waitFor(1'b1, 1'b1, 10700, n);
    chkTime(n, 2 + (33 + e) * TICK + 1);
    chkLvl(1'b1, 1'b1);
    i_pbseq_partner.host(1'b1);
    waitFor(1'b1, 1'b0, 3200, n);
    chkTime(n, KILL_FILT_CYC + 3);
    chkLvl(1'b0, 1'b0);
    $display("Test host_ack done");
    print_verdict();
  end
endmodule : test_push_button_power_sequencer
`default_nettype wire
